// [hw/dual_port_gpio.sv]
// Dual port GPIO with APB registers and slow falling-edge output
`timescale 1ns/1ns
module dual_port_gpio
    import gpio_pkg::*;
#(
    parameter logic [PA_W-1:0] PA_PULL_FITTED = 8'hFF,
    parameter logic [PA_W-1:0] PA_PULL_IS_UP = 8'h00,
    parameter logic [PB_W-1:0] PB_PULL_FITTED = 6'h3F,
    parameter logic [PB_W-1:0] PB_PULL_IS_UP = 6'h00
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [PA_W-1:0] pa_in,
    output logic [PA_W-1:0] pa_out,
    output logic [PA_W-1:0] pa_oe,
    output logic [PA_W-1:0] pa_pull_en,
    input wire logic [PB_W-1:0] pb_in,
    output logic [PB_W-1:0] pb_out,
    output logic [PB_W-1:0] pb_oe,
    output logic [PB_W-1:0] pb_pull_en,
    output logic [2:0] slow_driver_en
);
    logic [PA_W-1:0] port_a_data;
    logic [PB_W-1:0] port_b_data;
    logic [PA_W-1:0] port_a_direction;
    logic [PB_W-1:0] port_b_direction;
    logic [PA_W-1:0] port_a_pull_control;
    logic [PB_W-1:0] port_b_pull_control;
    logic slow_fall_enable;
    reg_sel_e sel;
    logic setup_phase;
    logic write_take;
    logic [PA_W-1:0] pa_read;
    logic [PB_W-1:0] pb_read;
    logic [DATA_W-1:0] next_prdata;

    slow_edge_if sif ();

    ////////////////////////////////////////////////////////////////////
    // Address decode, shared by the read and write paths
    function automatic reg_sel_e reg_select(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] idx;
        idx = a >> IDX_SHIFT;
        if (a[IDX_SHIFT-1:0] != '0)
            return SEL_NONE;
        else if (idx == ADDR_W'(IDX_PA_DATA))
            return SEL_PA_DATA;
        else if (idx == ADDR_W'(IDX_PB_DATA))
            return SEL_PB_DATA;
        else if (idx == ADDR_W'(IDX_PA_DIR))
            return SEL_PA_DIR;
        else if (idx == ADDR_W'(IDX_PB_DIR))
            return SEL_PB_DIR;
        else if (idx == ADDR_W'(IDX_SLOW_CTRL))
            return SEL_SLOW_CTRL;
        else if (idx == ADDR_W'(IDX_PA_PULL))
            return SEL_PA_PULL;
        else if (idx == ADDR_W'(IDX_PB_PULL))
            return SEL_PB_PULL;
        else
            return SEL_NONE;
    endfunction : reg_select

    assign sel = reg_select(paddr);
    assign setup_phase = psel & ~penable;
    // Zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign write_take = psel & penable & pwrite & pready & pstrb[0];

    ////////////////////////////////////////////////////////////////////
    // Data registers keep their contents through reset, so no reset here
    always_ff @(posedge pclk)
    begin
        if (write_take && sel == SEL_PA_DATA)
            port_a_data <= pwdata[PA_W-1:0];
        if (write_take && sel == SEL_PB_DATA)
            port_b_data <= pwdata[PB_W-1:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            port_a_direction <= PA_CTRL_RESET;
            port_b_direction <= PB_CTRL_RESET;
        end
        else
        begin
            if (write_take && sel == SEL_PA_DIR)
                port_a_direction <= pwdata[PA_W-1:0];
            if (write_take && sel == SEL_PB_DIR)
                port_b_direction <= pwdata[PB_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            port_a_pull_control <= PA_CTRL_RESET;
            port_b_pull_control <= PB_CTRL_RESET;
        end
        else
        begin
            if (write_take && sel == SEL_PA_PULL)
                port_a_pull_control <= pwdata[PA_W-1:0];
            if (write_take && sel == SEL_PB_PULL)
                port_b_pull_control <= pwdata[PB_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            slow_fall_enable <= 1'b0;
        else if (write_take && sel == SEL_SLOW_CTRL)
            slow_fall_enable <= pwdata[SLOW_BIT];
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs read the stored bit, inputs read the pin
    assign pa_read = (port_a_direction & port_a_data)
        | (~port_a_direction & pa_in);
    assign pb_read = (port_b_direction & port_b_data)
        | (~port_b_direction & pb_in);

    always_comb
    begin
        next_prdata = READ_ZERO;
        case (sel)
            SEL_PA_DATA: next_prdata[PA_W-1:0] = pa_read;
            SEL_PB_DATA: next_prdata[PB_W-1:0] = pb_read;
            SEL_PA_DIR: next_prdata[PA_W-1:0] = port_a_direction;
            SEL_PB_DIR: next_prdata[PB_W-1:0] = port_b_direction;
            SEL_SLOW_CTRL: next_prdata[SLOW_BIT] = slow_fall_enable;
            // Write-only pull control reads as zero
            default: next_prdata = READ_ZERO;
        endcase
    end

    // Read data is sampled in the setup cycle, one cycle before completion
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= READ_ZERO;
            pslverr <= 1'b0;
        end
        else if (setup_phase)
        begin
            prdata <= pwrite ? READ_ZERO : next_prdata;
            pslverr <= (sel == SEL_NONE);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Slow-edge shaper for the two coupled port B lines
    assign sif.slow_fall_enable = slow_fall_enable;
    assign sif.line_dir = {port_b_direction[PB_LINE2],
        port_b_direction[PB_LINE1]};
    assign sif.line_data = {port_b_data[PB_LINE2], port_b_data[PB_LINE1]};

    gpio_slow_edge u_slow_edge (
        .pclk(pclk),
        .presetn(presetn),
        .sif(sif)
    );

    // Slow driver engages only on lines set as outputs
    assign slow_driver_en = sif.slow_driver & {port_b_direction[PB_LINE1],
        port_a_direction[PA_LINE7], port_a_direction[PA_LINE6]};

    ////////////////////////////////////////////////////////////////////
    // Pins: A6, A7, B1, B2 are open drain, the rest push-pull
    always_comb
    begin
        pa_out = port_a_data;
        pa_oe = port_a_direction;
        pa_out[PA_LINE6] = 1'b0;
        pa_out[PA_LINE7] = 1'b0;
        pa_oe[PA_LINE6] = port_a_direction[PA_LINE6] & ~port_a_data[PA_LINE6];
        pa_oe[PA_LINE7] = port_a_direction[PA_LINE7] & ~port_a_data[PA_LINE7];
        pb_out = port_b_data;
        pb_oe = port_b_direction;
        pb_out[PB_LINE1] = 1'b0;
        pb_out[PB_LINE2] = 1'b0;
        pb_oe[PB_LINE1] = sif.line1_drive_low;
        pb_oe[PB_LINE2] = sif.line2_drive_low;
    end

    // Pulldowns give way to a driven output; pullups stay on regardless
    assign pa_pull_en = PA_PULL_FITTED & ~port_a_pull_control
        & (PA_PULL_IS_UP | ~port_a_direction);
    assign pb_pull_en = PB_PULL_FITTED & ~port_b_pull_control
        & (PB_PULL_IS_UP | ~port_b_direction);

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_dirb_upper_zero: assert property (
        setup_phase && !pwrite && sel == SEL_PB_DIR
        |=> prdata[7:6] == 2'b00 && prdata[5:0] == port_b_direction)
        else $error("port B direction upper bits not zero");

    chk_ctrl_reset: assert property (
        !$past(presetn) |-> port_b_direction == PB_CTRL_RESET
        && port_b_pull_control == PB_CTRL_RESET
        && port_a_direction == PA_CTRL_RESET)
        else $error("control registers not cleared by reset");

    chk_dir_readback: assert property (
        write_take && sel == SEL_PA_DIR
        ##2 (setup_phase && !pwrite && sel == SEL_PA_DIR)
        |=> prdata[PA_W-1:0] == $past(pwdata[PA_W-1:0], 3))
        else $error("port A direction did not read back");

    chk_out_follows: assert property (
        port_b_direction[0] |-> pb_oe[0] && pb_out[0] == port_b_data[0])
        else $error("output line does not follow data bit");

    chk_input_read: assert property (
        setup_phase && !pwrite && sel == SEL_PA_DATA
        && !port_a_direction[0]
        |=> prdata[0] == $past(pa_in[0])
        && prdata[DATA_W-1:PA_W] == '0)
        else $error("port A data read wrong");

    chk_input_stored: assert property (
        write_take && sel == SEL_PB_DATA && !port_b_direction[0]
        |=> port_b_data[0] == $past(pwdata[0]) && !pb_oe[0])
        else $error("input line write not stored or drove pin");

    chk_pulldown_off: assert property (
        port_b_direction[3] && !PB_PULL_IS_UP[3] |-> !pb_pull_en[3])
        else $error("pulldown active on output line");

    chk_pull_active: assert property (
        write_take && sel == SEL_PB_PULL && !pwdata[0]
        && (PB_PULL_IS_UP[0] || !port_b_direction[0])
        |=> pb_pull_en[0] == PB_PULL_FITTED[0])
        else $error("pull device not enabled by zero bit");

    chk_pull_read: assert property (
        setup_phase && !pwrite && sel == SEL_PB_PULL |=> prdata == '0)
        else $error("pull control read not zero");

    chk_line1_now: assert property (
        slow_fall_enable && port_b_direction[PB_LINE1]
        && $fell(port_b_data[PB_LINE1]) |-> pb_oe[PB_LINE1]
        && slow_driver_en[2])
        else $error("line 1 fall delayed or not slow");

    cov_slow_fall: cover property (
        slow_fall_enable && $fell(port_b_data[PB_LINE2])
        && port_b_direction[PB_LINE2] ##1 pb_oe[PB_LINE2]);
    cov_unmapped: cover property (psel && penable && pslverr);
    cov_read_pin: cover property (
        setup_phase && !pwrite && sel == SEL_PB_DATA
        && port_b_direction == '0);
endmodule : dual_port_gpio

// [hw/gpio_pkg.sv]
// Shared constants and types for the dual port GPIO block
package gpio_pkg;
    localparam int PA_W = 8;
    localparam int PB_W = 6;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_PA_DATA = 8'h00;
    localparam logic [7:0] IDX_PB_DATA = 8'h01;
    localparam logic [7:0] IDX_PA_DIR = 8'h04;
    localparam logic [7:0] IDX_PB_DIR = 8'h05;
    localparam logic [7:0] IDX_SLOW_CTRL = 8'h06;
    localparam logic [7:0] IDX_PA_PULL = 8'h10;
    localparam logic [7:0] IDX_PB_PULL = 8'h11;
    localparam int IDX_SHIFT = 2;
    // Field positions
    localparam int SLOW_BIT = 0;
    localparam int PA_LINE6 = 6;
    localparam int PA_LINE7 = 7;
    localparam int PB_LINE1 = 1;
    localparam int PB_LINE2 = 2;
    // Reset values
    localparam logic [PA_W-1:0] PA_CTRL_RESET = 8'h00;
    localparam logic [PB_W-1:0] PB_CTRL_RESET = 6'h00;
    localparam logic [DATA_W-1:0] READ_ZERO = 32'h00000000;
    // Timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int BUS_CYCLE_NS = 40;
    localparam int HALF_CYC_NS = BUS_CYCLE_NS / 2;
    localparam int HALF_CYC_RAW = (HALF_CYC_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int HALF_CYC_CYCLES = (HALF_CYC_RAW < 1) ? 1 : HALF_CYC_RAW;

    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_PA_DATA,
        SEL_PB_DATA,
        SEL_PA_DIR,
        SEL_PB_DIR,
        SEL_SLOW_CTRL,
        SEL_PA_PULL,
        SEL_PB_PULL
    } reg_sel_e;
endpackage : gpio_pkg

// [hw/slow_edge_if.sv]
// Signals between the port core and the slow falling-edge shaper
`timescale 1ns/1ns
interface slow_edge_if;
    logic slow_fall_enable;
    logic [1:0] line_dir;
    logic [1:0] line_data;
    logic line1_drive_low;
    logic line2_drive_low;
    logic [2:0] slow_driver;
    modport core (
        output slow_fall_enable,
        output line_dir,
        output line_data,
        input line1_drive_low,
        input line2_drive_low,
        input slow_driver
    );
    modport shaper (
        input slow_fall_enable,
        input line_dir,
        input line_data,
        output line1_drive_low,
        output line2_drive_low,
        output slow_driver
    );
endinterface : slow_edge_if

// [hw/gpio_slow_edge.sv]
// Slow falling-edge shaper for port B lines 1 and 2
`timescale 1ns/1ns
module gpio_slow_edge
    import gpio_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    slow_edge_if.shaper sif
);
    localparam int DLY = HALF_CYC_CYCLES;
    localparam int CW = $clog2(DLY + 1);
    logic wants_low1;
    logic wants_low2;
    logic line2_low;
    logic [CW-1:0] delay_count;

    assign wants_low1 = sif.line_dir[0] & ~sif.line_data[0];
    assign wants_low2 = sif.line_dir[1] & ~sif.line_data[1];

    // Line 1 pulls low at once, the slow driver softens its edge
    assign sif.line1_drive_low = wants_low1;
    // Release follows the data at once; only the fall waits
    assign sif.line2_drive_low = sif.slow_fall_enable
        ? (line2_low & wants_low2) : wants_low2;
    // Slow driver on all of {line1, A7, A6} while enabled; the core gates it to output lines
    assign sif.slow_driver = {3{sif.slow_fall_enable}};

    ////////////////////////////////////////////////////////////////////
    // Release is never delayed, only the falling edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            line2_low <= 1'b0;
            delay_count <= '0;
        end
        else if (!wants_low2)
        begin
            line2_low <= 1'b0;
            delay_count <= '0;
        end
        else if (!sif.slow_fall_enable)
        begin
            line2_low <= 1'b1;
            delay_count <= '0;
        end
        else if (!line2_low)
        begin
            if (delay_count == CW'(DLY - 1))
                line2_low <= 1'b1;
            else
                delay_count <= delay_count + CW'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////
    chk_line2_delay: assert property (
        @(posedge pclk) disable iff (!presetn)
        (sif.slow_fall_enable && $rose(wants_low2) && !$past(line2_low))
        |-> !sif.line2_drive_low ##1 sif.line2_drive_low)
        else $error("line 2 fall not delayed by half a bus cycle");
endmodule : gpio_slow_edge

// [bench/pin_board.sv]
// Board model: pin levels from drivers, pulls and test drive
`timescale 1ns/1ns
module pin_board #(
    parameter int W = 8,
    parameter logic [W-1:0] IS_UP = '0
)
(
    input wire logic pclk,
    input wire logic [W-1:0] out,
    input wire logic [W-1:0] oe,
    input wire logic [W-1:0] pull_en,
    input wire logic [W-1:0] ext_en,
    input wire logic [W-1:0] ext_val,
    output logic [W-1:0] level
);
    logic [W-1:0] last = '0;
    // Floating lines toggle so a stale level never passes as driven
    always_comb
    begin
        for (int i = 0; i < W; i++)
        begin
            if (oe[i])
                level[i] = out[i];
            else if (ext_en[i])
                level[i] = ext_val[i];
            else if (pull_en[i])
                level[i] = IS_UP[i];
            else
                level[i] = ~last[i];
        end
    end
    always_ff @(posedge pclk)
        last <= level;
endmodule : pin_board

// [bench/tb_top.sv]
// Self-checking testbench for the dual port GPIO block
`timescale 1ns/1ns
`define CHK(g, e) check(DATA_W'(g), DATA_W'(e))
module tb_top
    import gpio_pkg::*;
;
    localparam logic [PB_W-1:0] PB_UP = 6'h01;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [3:0] pstrb = 4'hF;
    logic [DATA_W-1:0] prdata, v;
    logic pready, pslverr, e;
    logic [PA_W-1:0] pa_in, pa_out, pa_oe, pa_pull_en;
    logic [PB_W-1:0] pb_in, pb_out, pb_oe, pb_pull_en;
    logic [PB_W-1:0] pb_ext_en = '0;
    logic [PB_W-1:0] pb_ext = '0;
    logic [2:0] slow_driver_en;
    int n_errors = 0;
    int n_compared = 0;

    always #(CLK_PERIOD_NS / 2) pclk = ~pclk;

    dual_port_gpio #(.PB_PULL_IS_UP(PB_UP)) dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe),
        .pa_pull_en(pa_pull_en), .pb_in(pb_in), .pb_out(pb_out),
        .pb_oe(pb_oe), .pb_pull_en(pb_pull_en),
        .slow_driver_en(slow_driver_en));
    pin_board #(.W(PA_W)) board_a (.pclk(pclk), .out(pa_out),
        .oe(pa_oe), .pull_en(pa_pull_en), .ext_en(8'h00),
        .ext_val(8'h00), .level(pa_in));
    pin_board #(.W(PB_W), .IS_UP(PB_UP)) board_b (.pclk(pclk),
        .out(pb_out), .oe(pb_oe), .pull_en(pb_pull_en),
        .ext_en(pb_ext_en), .ext_val(pb_ext), .level(pb_in));

    ////////////////////////////////////////////////////////////////////
    task automatic final_report;
        if (n_errors == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : final_report

    task automatic check(input logic [DATA_W-1:0] g,
        input logic [DATA_W-1:0] x);
        n_compared++;
        if (g !== x)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, g, x);
        end
    endtask : check

    // Request held until pready is sampled high at a rising edge
    task automatic apb(input logic w, input logic [7:0] idx,
        input logic [31:0] d, output logic [31:0] r, output logic er);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= idx << IDX_SHIFT;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        if (k >= 50)
        begin
            n_errors++;
            final_report();
        end
        else
        begin
            r = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            // Let this edge's register updates settle before callers look
            #1;
        end
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] r;
        logic er;
        apb(1'b1, idx, d, r, er);
    endtask : wr

    task automatic rd(input logic [7:0] idx, output logic [31:0] r);
        logic er;
        apb(1'b0, idx, 32'h0, r, er);
    endtask : rd

    ////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(IDX_PA_DIR, v);
        `CHK(v, 0);
        rd(IDX_PB_DIR, v);
        `CHK(v, 0);
        rd(IDX_PA_DATA, v);
        `CHK(v, 0);
        `CHK(pb_oe, 0);
        `CHK(pb_pull_en, 6'h3F);
        `CHK(pa_pull_en, 8'hFF);
    endtask : t_reset

    task automatic t_output;
        wr(IDX_PB_DATA, 32'h2B);
        wr(IDX_PB_DIR, 32'hFF);
        rd(IDX_PB_DIR, v);
        `CHK(v, 8'h3F);
        `CHK(pb_oe, 6'h3D);
        `CHK(pb_out, 6'h29);
        rd(IDX_PB_DATA, v);
        `CHK(v, 8'h2B);
        wr(IDX_PB_DATA, 32'hFF);
        rd(IDX_PB_DATA, v);
        `CHK(v, 8'h3F);
        wr(IDX_PA_DATA, 32'h3C);
        wr(IDX_PA_DIR, 32'hFF);
        `CHK({pa_oe, pa_out}, 16'hFF3C);
        rd(IDX_PA_DATA, v);
        `CHK(v, 8'h3C);
        wr(IDX_PA_DIR, 32'hA5);
        rd(IDX_PA_DIR, v);
        `CHK(v, 8'hA5);
    endtask : t_output

    task automatic t_input;
        wr(IDX_PB_PULL, 32'h0);
        wr(IDX_PB_DIR, 32'h0);
        @(posedge pclk);
        pb_ext_en <= 6'h3F;
        pb_ext <= 6'h15;
        rd(IDX_PB_DATA, v);
        `CHK(v, 8'h15);
        wr(IDX_PB_DATA, 32'h0B);
        `CHK(pb_oe, 0);
        rd(IDX_PB_DATA, v);
        `CHK(v, 8'h15);
        @(posedge pclk);
        pb_ext_en <= 6'h00;
        wr(IDX_PB_DIR, 32'h01);
        `CHK({pb_oe[0], pb_out[0]}, 2'b11);
    endtask : t_input

    task automatic t_pull;
        `CHK(pb_pull_en, 6'h3F);
        wr(IDX_PB_DIR, 32'h3F);
        `CHK(pb_pull_en, 6'h01);
        wr(IDX_PB_PULL, 32'h01);
        `CHK(pb_pull_en, 6'h00);
        wr(IDX_PB_PULL, 32'h3E);
        wr(IDX_PB_DIR, 32'h00);
        `CHK(pb_pull_en, 6'h01);
        wr(IDX_PA_PULL, 32'h0F);
        wr(IDX_PA_DIR, 32'h03);
        `CHK(pa_pull_en, 8'hF0);
    endtask : t_pull

    task automatic t_slow;
        wr(IDX_PB_DATA, 32'h06);
        wr(IDX_PB_DIR, 32'h06);
        wr(IDX_PA_DIR, 32'h40);
        wr(IDX_SLOW_CTRL, 32'h1);
        `CHK(slow_driver_en, 3'b101);
        wr(IDX_PB_DATA, 32'h00);
        #1;
        `CHK(pb_oe[2:1], 2'b01);
        @(posedge pclk);
        #1;
        `CHK(pb_oe[2:1], 2'b11);
        wr(IDX_PB_DATA, 32'h06);
        #1;
        `CHK(pb_oe[2:1], 2'b00);
        wr(IDX_SLOW_CTRL, 32'h0);
        `CHK(slow_driver_en, 3'b000);
        wr(IDX_PB_DATA, 32'h00);
        #1;
        `CHK(pb_oe[2:1], 2'b11);
    endtask : t_slow

    // Second reset must keep port B data but clear the controls
    task automatic t_rerun;
        wr(IDX_PB_DATA, 32'h15);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(IDX_PB_DIR, v);
        `CHK(v, 0);
        `CHK({slow_driver_en, pb_pull_en}, 9'h03F);
        wr(IDX_PB_DIR, 32'h3F);
        rd(IDX_PB_DATA, v);
        `CHK(v, 8'h15);
        apb(1'b0, 8'h07, 32'h0, v, e);
        `CHK(e, 1'b1);
        `CHK(v, 0);
    endtask : t_rerun

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_output();
        t_input();
        t_pull();
        t_slow();
        t_rerun();
        final_report();
    end

    initial
    begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        final_report();
    end
endmodule : tb_top
